// ---- common/ctfrc_pkg.sv ----
// Shared constants for the channel thermal fault restart control block
package ctfrc_pkg;
	localparam int         NUM_CH          = 4;
	localparam int         CH_IDX_W        = 2;
	localparam int         DATA_W          = 8;
	localparam int         ADDR_W          = 6;
	localparam int         DUR_W           = 6;
	// Command operating codes
	localparam logic [1:0] OP_WRITE        = 2'h0;
	localparam logic [1:0] OP_READ         = 2'h1;
	localparam logic [1:0] OP_RDCLR        = 2'h2;
	localparam logic [1:0] OP_DEVINFO      = 2'h3;
	// Register addresses and command data patterns
	localparam logic [5:0] ADDR_CFG_BASE   = 6'h10;
	localparam logic [5:0] ADDR_LCLR_BASE  = 6'h20;
	localparam logic [5:0] ADDR_FB_STATUS  = 6'h30;
	localparam logic [5:0] ADDR_LOFF_STAT  = 6'h31;
	localparam logic [5:0] ADDR_ALL        = 6'h3f;
	localparam logic [7:0] DATA_ALL_ONES   = 8'hff;
	localparam logic [7:0] DATA_ZERO       = 8'h00;
	// Field positions and reset values
	localparam int         GSB_LOFF_BIT    = 2;
	localparam int         GSB_TSD_BIT     = 4;
	localparam int         CFG_LATCH_BIT   = 7;
	localparam logic [7:0] CFG_RESET       = 8'h00;
	// Restart window tick
	localparam int         CLK_MHZ         = 50;
	localparam int         TICK_TIME_US    = 1000;
	localparam int         TICK_CYCLES     = TICK_TIME_US * CLK_MHZ;

	typedef enum logic [1:0] {
		ST_ON,
		ST_OFF_AUTO,
		ST_OFF_LATCH
	} ctfrc_prot_t;
endpackage

// ---- design/ctfrc_channel.sv ----
// One channel's protective shutdown and restart sequencer
`timescale 1ns/10ps
`default_nettype none
module ctfrc_channel
	import ctfrc_pkg::*;
(
	input  wire logic             i_ref_clk,
	input  wire logic             i_nrst,
	input  wire logic             i_tick,
	input  wire logic             i_limp,
	input  wire logic             i_latch_policy,
	input  wire logic [DUR_W-1:0] i_duration,
	input  wire logic             i_policy_chg,
	input  wire logic             i_ot,
	input  wire logic             i_ot_below_restart,
	input  wire logic             i_ot_below_status,
	input  wire logic             i_pl,
	input  wire logic             i_pl_below_restart,
	input  wire logic             i_loff_clear,
	input  wire logic             i_pl_status_clr,
	output logic                  o_enable,
	output logic                  o_ot_status,
	output logic                  o_pl_status,
	output logic                  o_loff_flag
);
	ctfrc_prot_t      state_q, state_d;
	logic [DUR_W-1:0] win_cnt_q;
	logic             win_run_q, win_exp_q;
	logic             ot_cause_q, pl_cause_q, clr_pend_q;
	logic             ot_stat_q, pl_stat_q, loff_q;

	wire trip      = (state_q == ST_ON) && (i_ot || i_pl);
	wire cool      = (!ot_cause_q || i_ot_below_restart) &&
	                 (!pl_cause_q || i_pl_below_restart);
	wire go_latch  = !i_limp && (i_latch_policy || win_exp_q);
	wire win_load  = trip && !win_run_q && !win_exp_q && !i_limp &&
	                 !i_latch_policy;
	wire win_last  = win_run_q && i_tick && (win_cnt_q <= DUR_W'(1));
	wire to_on     = (state_d == ST_ON) && (state_q != ST_ON);
	wire to_latch  = (state_d == ST_OFF_LATCH) && (state_q != ST_OFF_LATCH);

	// Off-state selection and restart conditions
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_ON: begin
				if (trip)
					state_d = go_latch ? ST_OFF_LATCH : ST_OFF_AUTO; // RL2 RL12
			end
			ST_OFF_AUTO: begin
				if (go_latch)
					state_d = ST_OFF_LATCH; // RL11
				else if (cool)
					state_d = ST_ON; // RL6 RL14
			end
			ST_OFF_LATCH: begin
				if (i_limp)
					state_d = ST_OFF_AUTO; // RL4
				else if (cool && clr_pend_q)
					state_d = ST_ON; // RL8 RL17
			end
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_q <= ST_ON;
		end else begin
			state_q <= state_d;
		end
	end

	// Restart window, armed at the first shutdown after a policy change
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			win_cnt_q <= '0;
			win_run_q <= 1'b0;
			win_exp_q <= 1'b0;
		end else if (i_policy_chg) begin
			win_run_q <= 1'b0; // RL18
			win_exp_q <= 1'b0;
		end else if (win_load) begin
			win_cnt_q <= i_duration; // RL18
			win_run_q <= (i_duration != '0);
			win_exp_q <= (i_duration == '0);
		end else if (win_last) begin
			win_run_q <= 1'b0; // RL11
			win_exp_q <= 1'b1;
		end else if (win_run_q && i_tick) begin
			win_cnt_q <= win_cnt_q - DUR_W'(1);
		end
	end

	// Causes, clear request and status flags; a set beats a clear, except that a restart drops the clear request
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ot_cause_q <= 1'b0;
			pl_cause_q <= 1'b0;
			clr_pend_q <= 1'b0;
			ot_stat_q  <= 1'b0;
			pl_stat_q  <= 1'b0;
			loff_q     <= 1'b0;
		end else begin
			ot_cause_q <= !to_on && (ot_cause_q || (i_ot && state_d != ST_ON));
			pl_cause_q <= !to_on && (pl_cause_q || (i_pl && state_d != ST_ON));
			clr_pend_q <= !to_on && (clr_pend_q ||
			              (i_loff_clear && state_q == ST_OFF_LATCH)); // RL8
			ot_stat_q  <= i_ot || (ot_stat_q &&
			              !(i_ot_below_status && state_q == ST_ON)); // RL1 RL7
			pl_stat_q  <= i_pl || (pl_stat_q &&
			              !(i_pl_status_clr && state_q == ST_ON)); // RL15 RL16
			loff_q     <= to_latch || (loff_q && !i_loff_clear); // RL9
		end
	end

	assign o_enable    = (state_q == ST_ON);
	assign o_ot_status = ot_stat_q;
	assign o_pl_status = pl_stat_q;
	assign o_loff_flag = loff_q;

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);

	sequence s_trip;
		(state_q == ST_ON) && (i_ot || i_pl);
	endsequence
	sequence s_stay_off;
		(state_q != ST_ON) [*2];
	endsequence

	chk_trip_off: assert property (s_trip |=> s_stay_off or (state_q != ST_ON)) // RL2
		else $error("Channel stayed on after a protective trip");
	chk_latch_hold: assert property ((state_q == ST_OFF_LATCH) && !clr_pend_q &&
		!i_loff_clear && !i_limp |=> !o_enable) // RL8
		else $error("Latched channel restarted without a clear write");
	chk_limp_auto: assert property (i_limp && (state_q != ST_ON) && !trip
		|=> state_q != ST_OFF_LATCH) // RL4
		else $error("Latch-off used in limp-home operation");
	chk_auto_restart: assert property ((state_q == ST_OFF_AUTO) && cool &&
		!go_latch |=> o_enable) // RL6
		else $error("Auto restart missed after cooling");
	chk_policy_reset: assert property (i_policy_chg |=> !win_exp_q && !win_run_q) // RL18
		else $error("Restart window not reset on policy change");
	chk_loff_clear: assert property (i_loff_clear && !to_latch |=> !o_loff_flag) // RL9
		else $error("Latch-off flag not cleared by clear write");
endmodule // ctfrc_channel
`default_nettype wire

// ---- design/ctfrc_top.sv ----
// Function
// RL1: Flag overtemperature above shutdown threshold
// RL2: Overtemperature turns channel off, sets feedback
// RL3: Overtemperature sets status bit 4, error
// RL4: Limp-home forces unlimited auto-restart
// RL5: Normal mode selects latch-off or timed
// RL6: Auto-restart resumes below restart temperature
// RL7: Overtemp status clears below reset temperature
// RL8: Latch-off needs cooling and clear write
// RL9: Clear write drops latch flag, bit 2
// RL10: Bit 2 stays while other latches active
// RL11: Timed restart expires into latch-off
// RL12: Power limit turns channel off, flags
// RL13: Power limit sets status bit 4, error
// RL14: Power limit auto-restart below restart threshold
// RL15: Power limit status cleared only by command
// RL16: Read-and-clear clears bits given as ones
// RL17: Power limit latch-off needs cooling, write
// RL18: Window counter loaded at shutdown, policy resets
// RL19: Enable, watchdog, software reset enter limp-home
`timescale 1ns/10ps
`default_nettype none
module ctfrc_top
	import ctfrc_pkg::*;
#(
	parameter int P_NUM_CH      = NUM_CH,
	parameter int P_TICK_CYCLES = TICK_CYCLES
) (
	input  wire logic                i_ref_clk,
	input  wire logic                i_nrst,
	input  wire logic [P_NUM_CH-1:0] i_ot_over_tsd,
	input  wire logic [P_NUM_CH-1:0] i_ot_below_restart,
	input  wire logic [P_NUM_CH-1:0] i_ot_below_status_reset,
	input  wire logic [P_NUM_CH-1:0] i_pl_over_threshold,
	input  wire logic [P_NUM_CH-1:0] i_pl_below_restart,
	input  wire logic                i_enable,
	input  wire logic                i_watchdog_toggle_timeout,
	input  wire logic                i_enter_normal,
	input  wire logic                i_cmd_valid,
	input  wire logic [1:0]          i_cmd_op,
	input  wire logic [ADDR_W-1:0]   i_cmd_addr,
	input  wire logic [DATA_W-1:0]   i_cmd_data,
	output logic [DATA_W-1:0]        o_rsp_data,
	output logic [DATA_W-1:0]        o_global_status_byte,
	output logic                     o_global_error,
	output logic [P_NUM_CH-1:0]      o_ch_enable,
	output logic                     o_limp_home
);
	localparam int SYNC_W = 5 * P_NUM_CH;
	localparam int TICK_W = $clog2(P_TICK_CYCLES);

	if (P_NUM_CH < 1 || P_NUM_CH > (1 << CH_IDX_W)) begin : g_bad_ch
		$error("P_NUM_CH must be 1 to 4");
	end
	if (P_TICK_CYCLES < 2) begin : g_bad_tick
		$error("P_TICK_CYCLES must be at least 2");
	end

	// Comparator inputs: three stages, a change counts when the last two stages agree
	logic [SYNC_W-1:0] s1_q, s2_q, s3_q, filt_q;
	wire  [SYNC_W-1:0] raw = {i_pl_below_restart, i_pl_over_threshold,
	                          i_ot_below_status_reset, i_ot_below_restart,
	                          i_ot_over_tsd};
	wire  [SYNC_W-1:0] filt_d = (s2_q & s3_q) | (filt_q & (s2_q | s3_q));

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			s1_q   <= '0;
			s2_q   <= '0;
			s3_q   <= '0;
			filt_q <= '0;
		end else begin
			s1_q   <= raw;
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			filt_q <= filt_d; // RL1
		end
	end

	wire [P_NUM_CH-1:0] ot_s     = filt_q[0 +: P_NUM_CH];
	wire [P_NUM_CH-1:0] ot_rst_s = filt_q[P_NUM_CH +: P_NUM_CH];
	wire [P_NUM_CH-1:0] ot_sts_s = filt_q[2*P_NUM_CH +: P_NUM_CH];
	wire [P_NUM_CH-1:0] pl_s     = filt_q[3*P_NUM_CH +: P_NUM_CH];
	wire [P_NUM_CH-1:0] pl_rst_s = filt_q[4*P_NUM_CH +: P_NUM_CH];

	// Command decode
	wire [CH_IDX_W-1:0] idx      = i_cmd_addr[CH_IDX_W-1:0];
	wire                is_write = i_cmd_valid && (i_cmd_op == OP_WRITE);
	wire                is_rdclr = i_cmd_valid && (i_cmd_op == OP_RDCLR);
	wire                in_cfg   = i_cmd_addr[ADDR_W-1:CH_IDX_W] ==
	                               ADDR_CFG_BASE[ADDR_W-1:CH_IDX_W];
	wire                in_lclr  = i_cmd_addr[ADDR_W-1:CH_IDX_W] ==
	                               ADDR_LCLR_BASE[ADDR_W-1:CH_IDX_W];
	wire                sw_reset = i_cmd_valid && (i_cmd_op == OP_DEVINFO) &&
	                               (i_cmd_addr == ADDR_ALL) &&
	                               (i_cmd_data != DATA_ALL_ONES);
	wire                clr_fb   = is_rdclr && (i_cmd_addr == ADDR_FB_STATUS);
	wire                clr_all  = is_rdclr && (i_cmd_addr == ADDR_ALL);
	wire [P_NUM_CH-1:0] pl_clr   = clr_all ? {P_NUM_CH{1'b1}} :
	                               (clr_fb ? i_cmd_data[P_NUM_CH-1:0] :
	                               {P_NUM_CH{1'b0}}); // RL16

	// Operating mode: limp-home after reset, normal on request
	logic limp_q;
	wire  limp_entry = !limp_q &&
	                   (!i_enable || i_watchdog_toggle_timeout || sw_reset);

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			limp_q <= 1'b1;
		end else if (limp_entry) begin
			limp_q <= 1'b1; // RL19
		end else if (i_enter_normal) begin
			limp_q <= 1'b0;
		end
	end

	// Restart window tick
	logic [TICK_W-1:0] tick_cnt_q;
	wire               tick = (tick_cnt_q == TICK_W'(P_TICK_CYCLES - 1));

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick ? '0 : tick_cnt_q + TICK_W'(1);
		end
	end

	// Per-channel policy registers and sequencers
	logic [DATA_W-1:0]   cfg_q [P_NUM_CH];
	logic [P_NUM_CH-1:0] ot_stat, pl_stat, loff_flag, ch_en;

	for (genvar c = 0; c < P_NUM_CH; c++) begin : g_ch
		wire sel     = (idx == CH_IDX_W'(c));
		wire cfg_wr  = is_write && in_cfg && sel;
		wire lclr_wr = is_write && in_lclr && sel;
		wire chg     = sw_reset || (cfg_wr && (i_cmd_data != cfg_q[c]));

		always_ff @(posedge i_ref_clk or negedge i_nrst) begin
			if (!i_nrst) begin
				cfg_q[c] <= CFG_RESET;
			end else if (sw_reset) begin
				cfg_q[c] <= CFG_RESET;
			end else if (cfg_wr) begin
				cfg_q[c] <= i_cmd_data; // RL5
			end
		end

		ctfrc_channel u_ch (
			.i_ref_clk          (i_ref_clk),
			.i_nrst             (i_nrst),
			.i_tick             (tick),
			.i_limp             (limp_q),
			.i_latch_policy     (cfg_q[c][CFG_LATCH_BIT]),
			.i_duration         (cfg_q[c][DUR_W-1:0]),
			.i_policy_chg       (chg),
			.i_ot               (ot_s[c]),
			.i_ot_below_restart (ot_rst_s[c]),
			.i_ot_below_status  (ot_sts_s[c]),
			.i_pl               (pl_s[c]),
			.i_pl_below_restart (pl_rst_s[c]),
			.i_loff_clear       (lclr_wr),
			.i_pl_status_clr    (pl_clr[c]),
			.o_enable           (ch_en[c]),
			.o_ot_status        (ot_stat[c]),
			.o_pl_status        (pl_stat[c]),
			.o_loff_flag        (loff_flag[c])
		);
	end

	// Status views
	wire [P_NUM_CH-1:0] fb_status = ot_stat | pl_stat; // RL2 RL12
	wire                any_fb    = |fb_status;
	wire                any_loff  = |loff_flag;
	logic [DATA_W-1:0]  global_status_byte;

	always_comb begin
		global_status_byte               = DATA_ZERO;
		global_status_byte[GSB_TSD_BIT]  = any_fb; // RL3 RL13
		global_status_byte[GSB_LOFF_BIT] = any_loff; // RL10
	end

	wire [DATA_W-1:0] fb_rd   = DATA_W'(fb_status);
	wire [DATA_W-1:0] loff_rd = DATA_W'(loff_flag);
	wire              idx_ok  = (32'(idx) < P_NUM_CH);
	wire [DATA_W-1:0] rd_mux  =
		(i_cmd_op == OP_DEVINFO)        ? DATA_ZERO :
		(i_cmd_addr == ADDR_FB_STATUS)  ? fb_rd :
		(i_cmd_addr == ADDR_LOFF_STAT)  ? loff_rd :
		(in_cfg && idx_ok)              ? cfg_q[idx] : DATA_ZERO;

	// Response holds the register content seen before the command acts
	logic [DATA_W-1:0] rsp_q, gsb_q;
	logic              err_q;

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rsp_q <= DATA_ZERO;
		end else if (i_cmd_valid) begin
			rsp_q <= rd_mux;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			gsb_q <= DATA_ZERO;
			err_q <= 1'b0;
		end else begin
			gsb_q <= global_status_byte;
			err_q <= any_fb || any_loff; // RL3 RL13
		end
	end

	assign o_rsp_data           = rsp_q;
	assign o_global_status_byte = gsb_q;
	assign o_global_error       = err_q;
	assign o_ch_enable          = ch_en;
	assign o_limp_home          = limp_q;

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);

	chk_gsb_tsd: assert property (any_fb |=>
		o_global_status_byte[GSB_TSD_BIT] && o_global_error) // RL3
		else $error("Global bit 4 or error flag missing on fault");
	chk_gsb_loff: assert property (any_loff |=>
		o_global_status_byte[GSB_LOFF_BIT]) // RL10
		else $error("Global bit 2 low while a latch-off is active");
	chk_limp_entry: assert property (!limp_q && !i_enable |=> limp_q) // RL19
		else $error("Limp-home not entered on enable clear");
	chk_pl_clear: assert property (clr_all && !(|pl_s) && (&ch_en)
		|=> !(|pl_stat)) // RL16
		else $error("Clear-all did not drop power limit status");

	sequence s_swrst_done;
		limp_q && (cfg_q[0] == CFG_RESET);
	endsequence

	chk_wdog_limp: assert property (!limp_q && i_watchdog_toggle_timeout // RL19
		|=> limp_q)
		else $error("Limp-home not entered on watchdog timeout");

	chk_swrst_limp: assert property (sw_reset |=> s_swrst_done) // RL19
		else $error("Software reset did not restore limp-home and policy");

	chk_normal_mode: assert property (limp_q && i_enter_normal |=> !limp_q)
		else $error("Normal mode request ignored");

	chk_err_any: assert property (any_fb || any_loff |=> o_global_error) // RL13
		else $error("Global error flag low while a fault is flagged");

	chk_gsb_idle: assert property (!any_fb && !any_loff |=> // RL9
		(o_global_status_byte == DATA_ZERO) && !o_global_error)
		else $error("Global status not cleared once faults are gone");

	chk_rsp_hold: assert property (!i_cmd_valid |=> $stable(o_rsp_data))
		else $error("Response changed without a command");

	// Per-channel trip, status latching and clearing
	for (genvar c = 0; c < P_NUM_CH; c++) begin : g_chk
		chk_ot_trip: assert property (@(posedge i_ref_clk) // RL2
			disable iff (!i_nrst) ot_s[c] && ch_en[c] |=> !ch_en[c])
			else $error("Channel stayed on during overtemperature");

		chk_pl_trip: assert property (@(posedge i_ref_clk) // RL12
			disable iff (!i_nrst) pl_s[c] && ch_en[c] |=> !ch_en[c])
			else $error("Channel stayed on during power limit");

		chk_ot_flag: assert property (@(posedge i_ref_clk) // RL1
			disable iff (!i_nrst) ot_s[c] |=> ot_stat[c])
			else $error("Overtemperature status not set");

		chk_pl_flag: assert property (@(posedge i_ref_clk) // RL12
			disable iff (!i_nrst) pl_s[c] |=> pl_stat[c])
			else $error("Power limit status not set");

		chk_fb_gsb: assert property (@(posedge i_ref_clk) // RL3
			disable iff (!i_nrst) ot_stat[c] || pl_stat[c] |=>
			o_global_status_byte[GSB_TSD_BIT])
			else $error("Global bit 4 low while a channel flag is set");

		chk_pl_keep: assert property (@(posedge i_ref_clk) // RL15
			disable iff (!i_nrst) pl_stat[c] && !pl_clr[c] |=> pl_stat[c])
			else $error("Power limit status dropped without a clear");

		chk_ot_keep: assert property (@(posedge i_ref_clk) // RL7
			disable iff (!i_nrst) ot_stat[c] && !ch_en[c] |=> ot_stat[c])
			else $error("Overtemperature status dropped while off");

		chk_ot_autoclr: assert property (@(posedge i_ref_clk) // RL7
			disable iff (!i_nrst) ot_stat[c] && ch_en[c] && ot_sts_s[c] &&
			!ot_s[c] |=> !ot_stat[c])
			else $error("Overtemperature status not cleared when cool");

		chk_pl_mask: assert property (@(posedge i_ref_clk) // RL16
			disable iff (!i_nrst) pl_stat[c] && ch_en[c] && pl_clr[c] &&
			!pl_s[c] |=> !pl_stat[c])
			else $error("Masked clear did not drop power limit status");

		chk_loff_gsb: assert property (@(posedge i_ref_clk) // RL10
			disable iff (!i_nrst) loff_flag[c] |=>
			o_global_status_byte[GSB_LOFF_BIT])
			else $error("Global bit 2 low while a channel is latched");
	end
endmodule // ctfrc_top
`default_nettype wire

// ---- testbench/ctfrc_thermal_model.sv ----
// Behavioural temperature comparators that feed the protection block
`timescale 1ns/10ps
`default_nettype none
module ctfrc_thermal_model #(
	parameter int         P_NUM_CH = 4,
	parameter logic [7:0] P_TSD    = 8'haa,
	parameter logic [7:0] P_TR     = 8'ha0,
	parameter logic [7:0] P_TRS    = 8'h96,
	parameter logic [7:0] P_PLM    = 8'h3c,
	parameter logic [7:0] P_PLR    = 8'h28
) (
	input  wire logic                    i_ref_clk,
	input  wire logic [P_NUM_CH-1:0][7:0] i_tj,
	input  wire logic [P_NUM_CH-1:0][7:0] i_dt,
	output var logic [P_NUM_CH-1:0]      o_ot_over,
	output var logic [P_NUM_CH-1:0]      o_ot_rst,
	output var logic [P_NUM_CH-1:0]      o_ot_srst,
	output var logic [P_NUM_CH-1:0]      o_pl_over,
	output var logic [P_NUM_CH-1:0]      o_pl_rst
);
	initial begin
		o_ot_over = '0;
		o_ot_rst  = '1;
		o_ot_srst = '1;
		o_pl_over = '0;
		o_pl_rst  = '1;
	end
	// Comparator outputs settle one clock after the temperature moves
	always @(posedge i_ref_clk) begin
		for (int c = 0; c < P_NUM_CH; c++) begin
			o_ot_over[c] <= i_tj[c] > P_TSD;
			o_ot_rst[c]  <= i_tj[c] < P_TR;
			o_ot_srst[c] <= i_tj[c] < P_TRS;
			o_pl_over[c] <= i_dt[c] > P_PLM;
			o_pl_rst[c]  <= i_dt[c] < P_PLR;
		end
	end
endmodule // ctfrc_thermal_model
`default_nettype wire

// ---- testbench/test_ctfrc_top.sv ----
// Self-checking bench for the channel protection sequencer
`timescale 1ns/10ps
`default_nettype none
module test_ctfrc_top;
	import ctfrc_pkg::*;
	typedef struct {logic [1:0] op; logic [5:0] a; logic [7:0] d, r;} ctfrc_row_t;
	logic i_ref_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic [3:0][7:0] tj = '0;
	logic [3:0][7:0] dt = '0;
	logic [3:0] ot_over, ot_rst, ot_srst, pl_over, pl_rst;
	logic i_enable = 1'b1;
	logic i_wd_to = 1'b0;
	logic i_enter_normal = 1'b0;
	logic i_cmd_valid = 1'b0;
	logic [1:0] i_cmd_op = 2'h0;
	logic [5:0] i_cmd_addr = 6'h00;
	logic [7:0] i_cmd_data = 8'h00;
	logic [7:0] o_rsp_data, o_global_status_byte;
	logic o_global_error, o_limp_home;
	logic [3:0] o_ch_enable;
	int err_total = 0;
	int comparisons = 0;
	int cyc = 0;
	ctfrc_row_t rows [7] = '{
		'{OP_WRITE, 6'h10, 8'h85, 8'h00}, '{OP_READ, 6'h10, 8'h00, 8'h85},
		'{OP_WRITE, 6'h10, 8'h00, 8'h85}, '{OP_READ, 6'h05, 8'h00, 8'h00},
		'{OP_DEVINFO, 6'h01, 8'h00, 8'h00}, '{OP_WRITE, 6'h30, 8'hff, 8'h00},
		'{OP_READ, 6'h31, 8'h00, 8'h00}};
	always #10 i_ref_clk = ~i_ref_clk;
	ctfrc_thermal_model u_model (.i_ref_clk(i_ref_clk), .i_tj(tj), .i_dt(dt),
		.o_ot_over(ot_over), .o_ot_rst(ot_rst), .o_ot_srst(ot_srst),
		.o_pl_over(pl_over), .o_pl_rst(pl_rst));
	ctfrc_top #(.P_NUM_CH(4), .P_TICK_CYCLES(4)) dut (.i_ref_clk(i_ref_clk),
		.i_nrst(i_nrst), .i_ot_over_tsd(ot_over), .i_ot_below_restart(ot_rst),
		.i_ot_below_status_reset(ot_srst), .i_pl_over_threshold(pl_over),
		.i_pl_below_restart(pl_rst), .i_enable(i_enable),
		.i_watchdog_toggle_timeout(i_wd_to), .i_enter_normal(i_enter_normal),
		.i_cmd_valid(i_cmd_valid), .i_cmd_op(i_cmd_op), .i_cmd_addr(i_cmd_addr),
		.i_cmd_data(i_cmd_data), .o_rsp_data(o_rsp_data),
		.o_global_status_byte(o_global_status_byte),
		.o_global_error(o_global_error), .o_ch_enable(o_ch_enable),
		.o_limp_home(o_limp_home));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			err_total++;
		end
	endtask
	task automatic cmd(input logic [1:0] op, input logic [5:0] a,
		input logic [7:0] d, input logic [7:0] r, input bit look);
		@(posedge i_ref_clk);
		i_cmd_valid <= 1'b1;
		i_cmd_op <= op;
		i_cmd_addr <= a;
		i_cmd_data <= d;
		@(posedge i_ref_clk);
		i_cmd_valid <= 1'b0;
		@(posedge i_ref_clk);
		#1;
		if (look)
			chk(o_rsp_data, r);
	endtask
	task automatic wait_ch(input int c, input logic v);
		int n;
		n = 0;
		while (o_ch_enable[c] !== v && n < 40) begin
			@(posedge i_ref_clk);
			n++;
		end
		#1;
		chk({7'h00, o_ch_enable[c]}, {7'h00, v});
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge i_ref_clk);
		#1;
	endtask
	task automatic go_normal;
		@(posedge i_ref_clk);
		i_enter_normal <= 1'b1;
		@(posedge i_ref_clk);
		i_enter_normal <= 1'b0;
		idle(2);
		chk({7'h00, o_limp_home}, 8'h00);
	endtask
	task automatic finish_test;
		$display("comparisons=%0d err_total=%0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge i_ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			finish_test();
		end
	end
	initial begin
		idle(2);
		i_nrst <= 1'b1;
		idle(1);
		chk({7'h00, o_limp_home}, 8'h01);
		chk({4'h0, o_ch_enable}, 8'h0f);
		chk(o_global_status_byte, 8'h00);
		chk({7'h00, o_global_error}, 8'h00);
		foreach (rows[i])
			cmd(rows[i].op, rows[i].a, rows[i].d, rows[i].r, 1'b1);
		// Overtemperature in limp-home restarts by itself
		tj[0] <= 8'hc8;
		wait_ch(0, 1'b0);
		idle(3);
		chk(o_global_status_byte, 8'h10);
		chk({7'h00, o_global_error}, 8'h01);
		cmd(OP_READ, ADDR_FB_STATUS, 8'h00, 8'h01, 1'b1);
		tj[0] <= 8'h64;
		wait_ch(0, 1'b1);
		idle(8);
		chk(o_global_status_byte, 8'h00);
		// Power limit status survives the restart until a masked clear
		dt[1] <= 8'h50;
		wait_ch(1, 1'b0);
		idle(3);
		chk(o_global_status_byte, 8'h10);
		dt[1] <= 8'h14;
		wait_ch(1, 1'b1);
		cmd(OP_READ, ADDR_FB_STATUS, 8'h00, 8'h02, 1'b1);
		cmd(OP_RDCLR, ADDR_FB_STATUS, 8'h01, 8'h02, 1'b1);
		cmd(OP_RDCLR, ADDR_FB_STATUS, 8'h02, 8'h02, 1'b1);
		cmd(OP_READ, ADDR_FB_STATUS, 8'h00, 8'h00, 1'b1);
		// Two latch-off channels in normal mode
		go_normal();
		cmd(OP_WRITE, 6'h12, 8'h80, 8'h00, 1'b1);
		cmd(OP_WRITE, 6'h13, 8'h80, 8'h00, 1'b1);
		tj[2] <= 8'hc8;
		dt[3] <= 8'h50;
		wait_ch(2, 1'b0);
		wait_ch(3, 1'b0);
		tj[2] <= 8'h64;
		dt[3] <= 8'h14;
		idle(30);
		chk({4'h0, o_ch_enable}, 8'h03);
		cmd(OP_READ, ADDR_LOFF_STAT, 8'h00, 8'h0c, 1'b1);
		chk(o_global_status_byte & 8'h04, 8'h04);
		cmd(OP_WRITE, 6'h22, 8'h01, 8'h00, 1'b0);
		idle(3);
		chk(o_global_status_byte & 8'h04, 8'h04);
		wait_ch(2, 1'b1);
		cmd(OP_READ, ADDR_LOFF_STAT, 8'h00, 8'h08, 1'b1);
		cmd(OP_WRITE, 6'h23, 8'h01, 8'h00, 1'b0);
		wait_ch(3, 1'b1);
		idle(3);
		chk(o_global_status_byte & 8'h04, 8'h00);
		// Two-tick window runs out while the junction stays hot
		cmd(OP_WRITE, 6'h10, 8'h02, 8'h00, 1'b1);
		tj[0] <= 8'hc8;
		wait_ch(0, 1'b0);
		idle(40);
		tj[0] <= 8'h64;
		idle(30);
		chk({7'h00, o_ch_enable[0]}, 8'h00);
		cmd(OP_READ, ADDR_LOFF_STAT, 8'h00, 8'h01, 1'b1);
		cmd(OP_WRITE, 6'h20, 8'h01, 8'h00, 1'b0);
		wait_ch(0, 1'b1);
		// Each way back into limp-home
		i_enable <= 1'b0;
		idle(3);
		chk({7'h00, o_limp_home}, 8'h01);
		i_enable <= 1'b1;
		go_normal();
		i_wd_to <= 1'b1;
		idle(1);
		i_wd_to <= 1'b0;
		idle(2);
		chk({7'h00, o_limp_home}, 8'h01);
		go_normal();
		cmd(OP_DEVINFO, ADDR_ALL, DATA_ALL_ONES, 8'h00, 1'b1);
		chk({7'h00, o_limp_home}, 8'h00);
		cmd(OP_DEVINFO, ADDR_ALL, DATA_ZERO, 8'h00, 1'b1);
		idle(1);
		chk({7'h00, o_limp_home}, 8'h01);
		cmd(OP_READ, 6'h10, 8'h00, CFG_RESET, 1'b1);
		finish_test();
	end
endmodule // test_ctfrc_top
`default_nettype wire
